// [rtl/adc_port_defs.svh]
// Offsets, field positions and timing counts of the serial register port
// Operation
// - Eight registers, reached only through serial port
// - Each access opens with a comms write
// - Readiness via ready pin or comms bit
// - Most registers are one byte frame
// - 24-bit register: one or three-byte transfers
// - Selected access ready right after eighth clock
// - Write setup keeps data output idle
// - Read setup ignores the data input
// - Strap tracks host clock idle level
// - Most significant bit first both ways
// - Chip select tied low still works
// - Host releases select after each transfer
// - Ready output may drive host interrupt
// - Free running host clock at most 3 MHz
// - Suggested power-up setup sequence for host
// - Ready low on result, high on read/update
// - 32 ones on input resynchronise port
// - Comms read top bit shows ready status
// - Strap high normal, low inverted clock
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH
`define REG_COUNT 8
`define REG_COMMS 3'h0
`define REG_MODE 3'h1
`define REG_FILT_HI 3'h2
`define REG_FILT_LO 3'h3
`define REG_TEST 3'h4
`define REG_DATA 3'h5
`define REG_ZERO_CAL 3'h6
`define REG_FULL_CAL 3'h7
`define WIDE_REG_FIRST 3'h5
`define COMMS_READY_BIT 7
`define COMMS_SEL_MSB 6
`define COMMS_SEL_LSB 4
`define COMMS_READ_BIT 3
`define SHORT_BITS 5'h08
`define WIDE_BITS 5'h18
`define RESYNC_ONES 6'h20
`define CLK_MHZ 50
`define HOST_HALF_NS 200
`define HOST_HALF_CYC (`HOST_HALF_NS * `CLK_MHZ / 1000)
`define HOST_IDLE_HIGH 1'h1
`endif

// [rtl/adc_port_pkg.sv]
// Types shared by both ends of the serial register port
package adc_port_pkg;
  typedef enum logic [1:0] {
    DEV_COMMS = 2'b00,
    DEV_WRITE = 2'b01,
    DEV_READ = 2'b10
  } dev_phase_t;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_RUN = 2'b01,
    HOST_TAIL = 2'b10
  } host_phase_t;

  typedef struct packed {
    dev_phase_t st;
    logic [7:0][23:0] regs;
    logic [23:0] shift;
    logic [4:0] cnt;
    logic [5:0] ones;
    logic [2:0] sel;
    logic [23:0] res_hold;
    logic load_pend;
    logic ready_n;
    logic dout;
    logic dout_oe_n;
    logic wr_stb;
    logic [2:0] wr_idx;
    logic [23:0] wr_val;
    logic sclk_s1, sclk_s2, din_s1, din_s2, cs_s1, cs_s2, pol_s1, pol_s2;
    logic ck_prev;
  } dev_state_t;

  typedef struct packed {
    host_phase_t st;
    logic [4:0] div;
    logic nck;
    logic sclk;
    logic cs_n;
    logic din;
    logic first;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [5:0] left;
    logic busy;
    logic done;
    logic dout_s1, dout_s2, rdy_s1, rdy_s2;
    logic ready_seen;
  } host_state_t;
endpackage

// [rtl/adc_port_if.sv]
// Pins between the converter port and its host
`timescale 1ns/1ps
`default_nettype none
interface adc_port_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe_n;
  logic dout_line;
  logic result_ready_n;
  logic clock_polarity_strap;

  // Pulled-up line while the converter leaves it undriven
  assign dout_line = dout_oe_n ? 1'b1 : dout;

  modport dev (
    input cs_n, sclk, din, clock_polarity_strap,
    output dout, dout_oe_n, result_ready_n
  );
  modport host (
    output cs_n, sclk, din, clock_polarity_strap,
    input dout_line, result_ready_n
  );
endinterface
`default_nettype wire

// [rtl/adc_port_host.sv]
// Host end: makes the serial clock and shifts one transfer per command
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_defs.svh"
module adc_port_host (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Link
  adc_port_if.host link,
  // User side
  input wire logic start,
  input wire logic [5:0] bit_count,
  input wire logic [31:0] tx_word,
  output logic busy,
  output logic done,
  output logic [31:0] rx_word,
  output logic ready_seen
);
  import adc_port_pkg::*;

  localparam logic [4:0] HALF = 5'(`HOST_HALF_CYC);

  host_state_t cur, next;
  logic tick;

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb begin
    next = cur;
    next.done = 1'b0;
    next.dout_s1 = link.dout_line;
    next.dout_s2 = cur.dout_s1;
    next.rdy_s1 = link.result_ready_n;
    next.rdy_s2 = cur.rdy_s1;
    next.ready_seen = ~cur.rdy_s2;
    tick = 1'b0;
    if (cur.st != HOST_IDLE) begin
      if (cur.div == HALF - 5'h01) begin
        tick = 1'b1;
        next.div = 5'h00;
      end else begin
        next.div = cur.div + 5'h01;
      end
    end
    case (cur.st)
      HOST_IDLE: begin
        if (start && bit_count != 6'h00) begin
          next.tx = tx_word;
          next.left = bit_count;
          next.cs_n = 1'b0;
          next.din = tx_word[31];
          next.nck = 1'b1;
          next.first = 1'b1;
          next.div = 5'h00;
          next.busy = 1'b1;
          next.rx = 32'h0;
          next.st = HOST_RUN;
        end
      end
      HOST_RUN: begin
        if (tick) begin
          if (cur.nck) begin
            next.nck = 1'b0;
            next.first = 1'b0;
            if (!cur.first) begin
              next.tx = {cur.tx[30:0], 1'b0};
              next.din = cur.tx[30];
            end
          end else begin
            next.nck = 1'b1;
            next.rx = {cur.rx[30:0], cur.dout_s2};
            next.left = cur.left - 6'h01;
            if (cur.left == 6'h01) begin
              next.st = HOST_TAIL;
            end
          end
        end
      end
      HOST_TAIL: begin
        if (tick) begin
          // Release select so a running clock is not seen
          next.cs_n = 1'b1;
          next.busy = 1'b0;
          next.done = 1'b1;
          next.st = HOST_IDLE;
        end
      end
      default: begin
        next.st = HOST_IDLE;
      end
    endcase
    // Idle level of the clock matches the strap
    next.sclk = `HOST_IDLE_HIGH ? next.nck : ~next.nck;
  end

  // ---------------------------------------------
  // State register
  // ---------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cur <= '0;
      cur.nck <= 1'b1;
      cur.sclk <= `HOST_IDLE_HIGH;
      cur.cs_n <= 1'b1;
      cur.dout_s1 <= 1'b1;
      cur.dout_s2 <= 1'b1;
      cur.rdy_s1 <= 1'b1;
      cur.rdy_s2 <= 1'b1;
    end else begin
      cur <= next;
    end
  end

  // ---------------------------------------------
  // Pins and user outputs
  // ---------------------------------------------
  assign link.cs_n = cur.cs_n;
  assign link.sclk = cur.sclk;
  assign link.din = cur.din;
  assign link.clock_polarity_strap = `HOST_IDLE_HIGH;
  assign busy = cur.busy;
  assign done = cur.done;
  assign rx_word = cur.rx;
  assign ready_seen = cur.ready_seen;
endmodule
`default_nettype wire

// [rtl/adc_port_dev.sv]
// Converter end: serial register port with eight registers
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_defs.svh"
module adc_port_dev (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Link
  adc_port_if.dev link,
  // Conversion side
  input wire logic new_result,
  input wire logic [23:0] result_word,
  // Register write notices
  output logic wr_stb,
  output logic [2:0] wr_idx,
  output logic [23:0] wr_val
);
  import adc_port_pkg::*;

  dev_state_t cur, next;
  logic ck, rise, resync;
  logic [7:0] cbyte;
  logic [4:0] last;
  logic [23:0] wval;

  // ---------------------------------------------
  // Register helpers
  // ---------------------------------------------
  // Register length in bits
  function automatic logic [4:0] reg_bits(input logic [2:0] idx);
    reg_bits = (idx >= `WIDE_REG_FIRST) ? `WIDE_BITS : `SHORT_BITS;
  endfunction

  // Read value left-aligned so bit 23 leaves first
  function automatic logic [23:0] read_val(input dev_state_t s, input logic [2:0] idx);
    logic [23:0] v;
    v = s.regs[idx];
    if (idx == `REG_COMMS) begin
      v[`COMMS_READY_BIT] = s.ready_n;
    end
    if (idx >= `WIDE_REG_FIRST) begin
      read_val = v;
    end else begin
      read_val = {v[7:0], 16'h0};
    end
  endfunction

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  // Pins come from another domain: two flops before any logic
  // Strap is resampled every cycle; it is meant to be wired fixed
  always_comb begin
    next = cur;
    next.wr_stb = 1'b0;
    next.sclk_s1 = link.sclk;
    next.sclk_s2 = cur.sclk_s1;
    next.din_s1 = link.din;
    next.din_s2 = cur.din_s1;
    next.cs_s1 = link.cs_n;
    next.cs_s2 = cur.cs_s1;
    next.pol_s1 = link.clock_polarity_strap;
    next.pol_s2 = cur.pol_s1;
    // Normalised clock idles high; strap low means inverted
    ck = cur.pol_s2 ? cur.sclk_s2 : ~cur.sclk_s2;
    next.ck_prev = ck;
    // Deselected: edges are not seen; tied-low select works
    rise = ck & ~cur.ck_prev & ~cur.cs_s2;
    cbyte = {cur.shift[6:0], cur.din_s2};
    last = reg_bits(cur.sel) - 5'h01;
    // Short registers keep only their own byte, not older frame bits
    if (reg_bits(cur.sel) == `SHORT_BITS) begin
      wval = {16'h0, cbyte};
    end else begin
      wval = {cur.shift[22:0], cur.din_s2};
    end

    // Ones are counted in every phase, reads included
    resync = rise && cur.din_s2 && (cur.ones >= `RESYNC_ONES - 6'h01);

    // ---------------------------------------------
    // Frame state machine
    // ---------------------------------------------
    if (rise) begin
      next.ones = cur.din_s2 ? cur.ones + 6'h01 : 6'h00;
      case (cur.st)
        DEV_COMMS: begin
          next.shift = {cur.shift[22:0], cur.din_s2};
          next.cnt = cur.cnt + 5'h01;
          if (cur.cnt == `SHORT_BITS - 5'h01) begin
            // Every access is chosen here
            next.cnt = 5'h00;
            next.regs[`REG_COMMS][7:0] = cbyte;
            next.sel = cbyte[`COMMS_SEL_MSB:`COMMS_SEL_LSB];
            if (cbyte[`COMMS_READ_BIT]) begin
              next.st = DEV_READ;
              next.shift = read_val(cur, cbyte[`COMMS_SEL_MSB:`COMMS_SEL_LSB]);
            end else begin
              next.st = DEV_WRITE;
            end
          end
        end
        DEV_WRITE: begin
          next.shift = {cur.shift[22:0], cur.din_s2};
          next.cnt = cur.cnt + 5'h01;
          if (cur.cnt == last) begin
            // Byte frames keep counting across select gaps
            next.cnt = 5'h00;
            next.st = DEV_COMMS;
            next.wr_stb = 1'b1;
            next.wr_idx = cur.sel;
            // Notice pulses even for registers that store nothing
            next.wr_val = wval;
            // Result register and comms are not written here
            if (cur.sel != `REG_DATA && cur.sel != `REG_COMMS) begin
              next.regs[cur.sel] = wval;
            end
          end
        end
        DEV_READ: begin
          // Input bits dropped while reading
          next.shift = {cur.shift[22:0], 1'b0};
          next.cnt = cur.cnt + 5'h01;
          if (cur.cnt == last) begin
            next.cnt = 5'h00;
            next.st = DEV_COMMS;
            if (cur.sel == `REG_DATA) begin
              next.ready_n = 1'b1;
            end
          end
        end
        default: begin
          next.st = DEV_COMMS;
          next.cnt = 5'h00;
        end
      endcase
      // Long run of ones resets only the framing
      if (resync) begin
        next.ones = `RESYNC_ONES;
        next.st = DEV_COMMS;
        next.cnt = 5'h00;
        // A frame ended by the same edge must not touch the registers
        next.regs = cur.regs;
        next.sel = cur.sel;
        next.wr_stb = 1'b0;
        next.wr_idx = cur.wr_idx;
        next.wr_val = cur.wr_val;
      end
    end

    // ---------------------------------------------
    // Result register update
    // ---------------------------------------------
    // Result update after the read clear, so a new result wins
    if (cur.load_pend) begin
      next.regs[`REG_DATA] = cur.res_hold;
      next.ready_n = 1'b0;
      next.load_pend = 1'b0;
    end
    if (new_result) begin
      // Raised one cycle ahead of the update
      next.ready_n = 1'b1;
      next.res_hold = result_word;
      next.load_pend = 1'b1;
    end

    // ---------------------------------------------
    // Data output
    // ---------------------------------------------
    // Undriven line floats to the pull-up, so the host reads ones
    // Output idle unless selected and reading
    next.dout_oe_n = ~(next.st == DEV_READ && ~cur.cs_s2);
    next.dout = (next.st == DEV_READ) ? next.shift[23] : 1'b0;
  end

  // ---------------------------------------------
  // State register
  // ---------------------------------------------
  // Sync flops reset to idle levels so no false edge follows reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cur <= '0;
      cur.ready_n <= 1'b1;
      cur.dout_oe_n <= 1'b1;
      cur.cs_s1 <= 1'b1;
      cur.cs_s2 <= 1'b1;
      cur.pol_s1 <= 1'b1;
      cur.pol_s2 <= 1'b1;
      cur.sclk_s1 <= 1'b1;
      cur.sclk_s2 <= 1'b1;
      cur.ck_prev <= 1'b1;
    end else begin
      cur <= next;
    end
  end

  // ---------------------------------------------
  // Pins and write notices
  // ---------------------------------------------
  // All outputs come straight from the state register
  assign link.dout = cur.dout;
  assign link.dout_oe_n = cur.dout_oe_n;
  assign link.result_ready_n = cur.ready_n;
  assign wr_stb = cur.wr_stb;
  assign wr_idx = cur.wr_idx;
  assign wr_val = cur.wr_val;
endmodule
`default_nettype wire

// [sim/adc_port_props.sv]
// Concurrent checks on the link between the two ends of the serial port
`timescale 1ns/1ps
`default_nettype none
module adc_port_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe_n,
  input wire logic result_ready_n,
  input wire logic clock_polarity_strap
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [3:0] since_rise;
  // ---------------------------------------------
  // Cycles since serial clock rose
  // ---------------------------------------------
  // Saturates so a long idle never wraps back
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      since_rise <= 4'hf;
    end else if ($rose(sclk)) begin
      since_rise <= 4'h0;
    end else if (since_rise != 4'hf) begin
      since_rise <= since_rise + 4'h1;
    end
  end
  sequence s_frame_end;
    $rose(cs_n);
  endsequence
  sequence s_idle;
    cs_n [*8];
  endsequence
  sequence s_dout_moves;
    !dout_oe_n && !$fell(dout_oe_n) && $changed(dout);
  endsequence
  AST_STRAP_IDLE: assert property (cs_n [*3] |-> sclk == clock_polarity_strap)
    else $error("serial clock away from strap level while idle");
  AST_SCLK_HALF: assert property ($changed(sclk) |=> $stable(sclk) [*8])
    else $error("serial clock half period too short");
  AST_DIN_EDGE: assert property ($changed(din) && !cs_n && !$fell(cs_n) |-> !sclk)
    else $error("data in changed while clock high");
  AST_CS_END: assert property (s_frame_end |-> sclk && $past(sclk, 8))
    else $error("select released too soon after last clock");
  AST_OE_RELEASE: assert property (s_frame_end |-> ##[1:6] dout_oe_n)
    else $error("data out still driven after select release");
  AST_OE_IDLE: assert property (s_idle |-> dout_oe_n)
    else $error("data out driven while deselected");
  AST_OE_FALL: assert property ($fell(dout_oe_n) |-> !cs_n && sclk)
    else $error("data out driven at wrong moment");
  AST_DOUT_EDGE: assert property (s_dout_moves |-> since_rise < 4'h8)
    else $error("data out changed away from clock edge");
endmodule
`default_nettype wire

// [sim/tb_adc_serial_register_port.sv]
// Self-checking bench: host end and converter end joined over the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; \
  if ((g) !== (e)) begin fails++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_adc_serial_register_port;
  import adc_port_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic start, busy, done, ready_seen, new_result, wr_stb;
  logic [5:0] bit_count;
  logic [31:0] tx_word, rx_word, rx;
  logic [23:0] result_word, wr_val, got_val, w, acc, rw;
  logic [2:0] wr_idx, got_idx;
  logic [7:0] v;
  logic [23:0] exp_reg [8];
  int fails, num_checks, stb_cnt, s;
  always #10 clk_sys = ~clk_sys;
  adc_port_if i_adc_port_if ();
  adc_port_host i_adc_port_host (.clk_sys(clk_sys), .rstn(rstn), .link(i_adc_port_if.host),
    .start(start), .bit_count(bit_count), .tx_word(tx_word), .busy(busy), .done(done),
    .rx_word(rx_word), .ready_seen(ready_seen));
  adc_port_dev i_adc_port_dev (.clk_sys(clk_sys), .rstn(rstn), .link(i_adc_port_if.dev),
    .new_result(new_result), .result_word(result_word), .wr_stb(wr_stb), .wr_idx(wr_idx),
    .wr_val(wr_val));
  adc_port_props i_adc_port_props (.clk_sys(clk_sys), .rstn(rstn), .cs_n(i_adc_port_if.cs_n),
    .sclk(i_adc_port_if.sclk), .din(i_adc_port_if.din), .dout(i_adc_port_if.dout),
    .dout_oe_n(i_adc_port_if.dout_oe_n), .result_ready_n(i_adc_port_if.result_ready_n),
    .clock_polarity_strap(i_adc_port_if.clock_polarity_strap));
  always @(posedge clk_sys) begin
    if (wr_stb === 1'b1) begin
      stb_cnt++;
      got_idx = wr_idx;
      got_val = wr_val;
    end
  end
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic [7:0] comms(input logic [2:0] idx, input logic rd);
    return {1'b0, idx, rd, 3'h0};
  endfunction
  task automatic xfer(input logic [5:0] n, input logic [31:0] wd);
    @(posedge clk_sys);
    start <= 1'b1;
    bit_count <= n;
    tx_word <= wd;
    @(posedge clk_sys);
    start <= 1'b0;
    @(negedge clk_sys);
    `CHK("busy", 1'b1, busy)
    for (int i = 0; i < 800 && done !== 1'b1; i++) @(negedge clk_sys);
    `CHK("done", 1'b1, done)
    repeat (6) @(posedge clk_sys);
    rx = rx_word;
    `CHK("busy", 1'b0, busy)
  endtask
  task tally_and_finish();
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Run is about 40 transfers of at most 700 cycles; allow twice that
  initial begin
    #1_200_000;
    fails++;
    tally_and_finish();
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    start = 1'b0;
    bit_count = 6'h00;
    tx_word = 32'h0;
    new_result = 1'b0;
    result_word = 24'h0;
    void'($urandom(32'h792f));
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (12) @(posedge clk_sys);
    // Power-up style setup: mode, filter and test byte registers written, then read back
    for (int i = 1; i < 5; i++) begin
      v = (i == 1) ? 8'h00 : (i == 4) ? 8'hff : 8'($urandom);
      s = stb_cnt;
      xfer(6'h10, {comms(3'(i), 1'b0), v, 16'h0});
      `CHK("strobe count", s + 1, stb_cnt)
      `CHK("write index", 3'(i), got_idx)
      `CHK("write value", {16'h0, v}, got_val)
      xfer(6'h10, {comms(3'(i), 1'b1), 8'($urandom), 16'h0});
      // Pulled-up line shows ones while the comms byte goes out
      `CHK("byte read", {16'h0, 8'hff, v}, rx)
    end
    for (int i = 6; i < 8; i++) begin
      w = 24'($urandom);
      xfer(6'h20, {comms(3'(i), 1'b0), w});
      `CHK("wide write", w, got_val)
      xfer(6'h08, {comms(3'(i), 1'b1), 24'h0});
      for (int k = 0; k < 3; k++) begin
        xfer(6'h08, {8'($urandom), 24'h0});
        acc = {acc[15:0], rx[7:0]};
      end
      `CHK("split read", w, acc)
      w = 24'($urandom);
      xfer(6'h08, {comms(3'(i), 1'b0), 24'h0});
      for (int k = 2; k >= 0; k--) xfer(6'h08, {w[8*k +: 8], 24'h0});
      `CHK("split write", w, got_val)
      xfer(6'h20, {comms(3'(i), 1'b1), 24'h0});
      `CHK("wide read", w, rx[23:0])
      exp_reg[i] = w;
    end
    rw = 24'($urandom);
    @(posedge clk_sys);
    new_result <= 1'b1;
    result_word <= rw;
    @(posedge clk_sys);
    new_result <= 1'b0;
    repeat (8) @(posedge clk_sys);
    `CHK("ready seen", 1'b1, ready_seen)
    xfer(6'h10, {comms(3'h0, 1'b1), 24'h0});
    `CHK("status bit", 1'b0, rx[7])
    xfer(6'h20, {comms(3'h5, 1'b1), 24'h0});
    `CHK("result", rw, rx[23:0])
    `CHK("ready cleared", 1'b0, ready_seen)
    xfer(6'h10, {comms(3'h0, 1'b1), 24'h0});
    `CHK("status idle", 1'b1, rx[7])
    xfer(6'h20, {comms(3'h5, 1'b0), ~rw});
    xfer(6'h20, {comms(3'h5, 1'b1), 24'h0});
    `CHK("result kept", rw, rx[23:0])
    s = stb_cnt;
    xfer(6'h08, {comms(3'h6, 1'b1), 24'h0});
    xfer(6'h20, 32'hffffffff);
    `CHK("read under ones", exp_reg[6], rx[31:8])
    `CHK("no write", s, stb_cnt)
    xfer(6'h10, {comms(3'h2, 1'b0), 8'h5a, 16'h0});
    `CHK("after resync", 3'h2, got_idx)
    xfer(6'h20, {comms(3'h6, 1'b1), 24'h0});
    `CHK("kept register", exp_reg[6], rx[23:0])
    tally_and_finish();
  end
endmodule
`default_nettype wire
